// ===== core/speed_ctrl_params.svh
// Constants shared by the working speed control link ends.
`ifndef SPEED_CTRL_PARAMS_SVH
`define SPEED_CTRL_PARAMS_SVH
`define SC_CLK_HZ 100000000
`define SC_BAUD_500K 500000
`define SC_BAUD_250K 250000
`define SC_BIT_500K (`SC_CLK_HZ / `SC_BAUD_500K)
`define SC_BIT_250K (`SC_CLK_HZ / `SC_BAUD_250K)
`define SC_GAP_BITS 11
`define SC_REQ_ID 29'h18ef71c9
`define SC_ACT_BIT 0
`define SC_SPEED_LSB 32
`define SC_SPEED_LEN 16
`define SC_FRAME_BITS 93
`define SC_RPM_MIN 16'h03e8
`define SC_RPM_MAX 16'h0ed8
`define SC_RPM_STEP 16'h0064
`define SC_RPM_STAGE1 16'h05dc
`define SC_RPM_STAGE2 16'h07d0
`define SC_RPM_BYPASS 16'h04b0
`define SC_RPM_SAFE 16'h03e8
`define SC_RAMP_SAFE 8'h0a
`define SC_TICK_NS 1000000
`define SC_TICK_CYCLES (`SC_TICK_NS / 10)
`define SC_TIMEOUT_RST 16'h0064
`define SC_DEV_CTRL 5'h00
`define SC_DEV_SETPT 5'h04
`define SC_DEV_RAMP 5'h08
`define SC_DEV_TMO 5'h0c
`define SC_DEV_STAT 5'h10
`define SC_DEV_IRQST 5'h14
`define SC_DEV_IRQEN 5'h18
`define SC_DEV_IRQCLR 5'h1c
`define SC_HST_SPEED 4'h0
`define SC_HST_CTRL 4'h4
`define SC_HST_STAT 4'h8
`define SC_HST_SEND 4'hc
`endif

// ===== core/speed_ctrl_pkg.sv
// Types and shared helpers for the working speed control link.
package speed_ctrl_pkg;
    typedef enum {RxIdle, RxStart, RxData} rxState_t;
    typedef enum {TxIdle, TxBits, TxGap} txState_t;
    typedef logic [15:0] rpm_t;

    // Payload bit 0 travels first on the line, so the shift order flips.
    function automatic logic [63:0] reverse64(input logic [63:0] v);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 64; i++) begin
            r[i] = v[63 - i];
        end
        return r;
    endfunction
endpackage

// ===== core/speed_link_if.sv
// Wired-AND serial line joining the converter controller and the device.
`timescale 1ns/1ps
interface speed_link_if;
    logic hostOut;
    logic hostOe;
    logic devOut;
    logic devOe;
    logic line;

    // Dominant low wins; an undriven line idles recessive high.
    assign line = (hostOe && !hostOut) || (devOe && !devOut) ? 1'b0 : 1'b1;

    modport device (input line, output devOut, output devOe);
    modport host (input line, output hostOut, output hostOe);
endinterface

// ===== core/speed_ctrl_device.sv
// Working speed control end: request receiver, limiter, ramp and bypass.
// Operation
// - Default 500 kBaud, 250 kBaud with telematics
// - Air heater fitted forces 500 kBaud
// - Accept only extended identifier 0x18EF71C9
// - Activation flag sits at payload bit 0
// - Target speed: payload bits 32..47, rpm
// - Active request frames lock out wired inputs
// - Clear flag or failure re-enables wired inputs
// - Fixed stages: 1000, 1500, 2000 rpm
// - Variable: 1000 to 3800 in 100 steps
// - Never regulate above 3800 rpm
// - Below 1300 rpm base vehicle may override
// - Ramp value zero holds engine speed
// - Safe low defaults until values validated
// - Engine protection may cut actual speed
// - Speed above 1200 rpm clears bypass
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "speed_ctrl_params.svh"
module speed_ctrl_device import speed_ctrl_pkg::*; #(
    parameter int TickCycles = `SC_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [4:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    speed_link_if.device link,
    input wire logic speedUpPin,
    input wire logic speedDownPin,
    input wire logic bypassReqPin,
    input wire logic [15:0] protectLimit,
    output logic [15:0] speedCmd,
    output logic bypassActive,
    output logic hwInputsEnabled,
    output logic irq
);
    initial begin
        if (TickCycles < 2) $error("TickCycles must be at least 2");
    end

    // Keeps any setting inside 1000..3800 on a 100 rpm grid.
    function automatic rpm_t limitRpm(input rpm_t v);
        if (v > `SC_RPM_MAX) return `SC_RPM_MAX;
        if (v < `SC_RPM_MIN) return `SC_RPM_MIN;
        return v - (v % `SC_RPM_STEP);
    endfunction

    logic [3:0] ctrl_q;
    rpm_t setpt_q;
    logic [1:0] stage_q;
    logic [7:0] ramp_q;
    logic [15:0] tmo_q;
    logic [2:0] irqSt_q, irqEn_q;
    logic canActive_q, msgFail_q;
    rpm_t canSpeed_q;
    logic frameOk_q, bypassClr_q;
    logic wbAck_q;
    logic [31:0] wbDatR_q;
    logic [2:0] upSync_q, dnSync_q, bpSync_q;
    logic [2:0] lineSync_q;
    rxState_t rxState_q;
    logic [15:0] rxCnt_q;
    logic [6:0] rxBits_q;
    logic [92:0] rxShift_q;
    logic [31:0] tick_q;
    logic [15:0] idle_q;
    rpm_t speed_q;
    logic bypass_q;
    logic irq_q;
    logic variableOpt, rate250, validated, wbWr, tickHit;
    logic upEdge, dnEdge, bpEdge;
    logic [15:0] bitCycles;
    logic [63:0] payload;
    rpm_t target, capped;

    assign variableOpt = ctrl_q[0];
    assign validated = ctrl_q[3];
    assign rate250 = ctrl_q[1] && !ctrl_q[2];
    assign bitCycles = rate250 ? 16'(`SC_BIT_250K) : 16'(`SC_BIT_500K);
    assign wbWr = wbCyc && wbStb && wbWe && !wbAck_q && wbSel[0];
    assign tickHit = tick_q == 32'(TickCycles - 1);
    assign payload = reverse64(rxShift_q[63:0]);
    assign upEdge = upSync_q[1] && !upSync_q[2];
    assign dnEdge = dnSync_q[1] && !dnSync_q[2];
    assign bpEdge = bpSync_q[1] && !bpSync_q[2];

    // The receiver never transmits; the line is left to the host.
    assign link.devOut = 1'b1;
    assign link.devOe = 1'b0;

    // Pins cross in through two flops; the third only feeds edge detects.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            upSync_q <= 3'h0;
            dnSync_q <= 3'h0;
            bpSync_q <= 3'h0;
            lineSync_q <= 3'h7;
        end else begin
            upSync_q <= {upSync_q[1:0], speedUpPin};
            dnSync_q <= {dnSync_q[1:0], speedDownPin};
            bpSync_q <= {bpSync_q[1:0], bypassReqPin};
            lineSync_q <= {lineSync_q[1:0], link.line};
        end
    end

    // Serial receiver, sampling each bit at its centre.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxState_q <= RxIdle;
            rxCnt_q <= 16'h0;
            rxBits_q <= 7'h0;
            rxShift_q <= '0;
            frameOk_q <= 1'b0;
        end else begin
            frameOk_q <= 1'b0;
            unique case (rxState_q)
                RxIdle: begin
                    rxCnt_q <= 16'h0;
                    if (!lineSync_q[1] && lineSync_q[2]) begin
                        rxState_q <= RxStart;
                    end
                end
                RxStart: begin
                    rxCnt_q <= rxCnt_q + 16'h1;
                    if (rxCnt_q == (bitCycles >> 1)) begin
                        rxCnt_q <= 16'h0;
                        rxBits_q <= 7'h0;
                        rxState_q <= lineSync_q[1] ? RxIdle : RxData;
                    end
                end
                RxData: begin
                    rxCnt_q <= rxCnt_q + 16'h1;
                    if (rxCnt_q == bitCycles - 16'h1) begin
                        rxCnt_q <= 16'h0;
                        rxShift_q <= {rxShift_q[91:0], lineSync_q[1]};
                        rxBits_q <= rxBits_q + 7'h1;
                        if (rxBits_q == 7'(`SC_FRAME_BITS - 1)) begin
                            rxState_q <= RxIdle;
                            frameOk_q <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Request state: active flag, speed and failure supervision.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            canActive_q <= 1'b0;
            canSpeed_q <= `SC_RPM_SAFE;
            msgFail_q <= 1'b0;
            idle_q <= 16'h0;
        end else if (frameOk_q && rxShift_q[92:64] == `SC_REQ_ID) begin
            canActive_q <= payload[`SC_ACT_BIT];
            canSpeed_q <= payload[`SC_SPEED_LSB +: `SC_SPEED_LEN];
            msgFail_q <= 1'b0;
            idle_q <= 16'h0;
        end else if (tickHit && canActive_q) begin
            idle_q <= idle_q + 16'h1;
            if (idle_q + 16'h1 >= tmo_q) begin
                canActive_q <= 1'b0;
                msgFail_q <= 1'b1;
            end
        end
    end

    // Bus writes to configuration; wired inputs step only when unlocked.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 4'h0;
            setpt_q <= `SC_RPM_SAFE;
            stage_q <= 2'h0;
            ramp_q <= `SC_RAMP_SAFE;
            tmo_q <= `SC_TIMEOUT_RST;
            irqEn_q <= 3'h0;
        end else if (wbWr) begin
            unique case (wbAdr)
                `SC_DEV_CTRL: ctrl_q <= wbDatW[3:0];
                `SC_DEV_SETPT: begin
                    setpt_q <= limitRpm(wbDatW[15:0]);
                    stage_q <= wbDatW[17:16] > 2'h2 ? 2'h2 : wbDatW[17:16];
                end
                `SC_DEV_RAMP: ramp_q <= wbDatW[7:0];
                `SC_DEV_TMO: tmo_q <= wbDatW[15:0];
                `SC_DEV_IRQEN: irqEn_q <= wbDatW[2:0];
                default: ;
            endcase
        end else if (!canActive_q) begin
            if (variableOpt && upEdge) begin
                setpt_q <= limitRpm(setpt_q + `SC_RPM_STEP);
            end else if (variableOpt && dnEdge) begin
                setpt_q <= limitRpm(setpt_q - `SC_RPM_STEP);
            end else if (!variableOpt && upEdge && stage_q != 2'h2) begin
                stage_q <= stage_q + 2'h1;
            end else if (!variableOpt && dnEdge && stage_q != 2'h0) begin
                stage_q <= stage_q - 2'h1;
            end
        end
    end

    // Target selection and limiting.
    always_comb begin
        if (!validated) begin
            target = `SC_RPM_SAFE;
        end else if (canActive_q && variableOpt) begin
            target = limitRpm(canSpeed_q);
        end else if (variableOpt) begin
            target = setpt_q;
        end else begin
            unique case (stage_q)
                2'h1: target = `SC_RPM_STAGE1;
                2'h2: target = `SC_RPM_STAGE2;
                default: target = `SC_RPM_MIN;
            endcase
        end
        capped = protectLimit < target ? protectLimit : target;
        if (capped > `SC_RPM_MAX) capped = `SC_RPM_MAX;
    end

    // Ramp toward the target once per tick; a larger step lands exactly.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_q <= 32'h0;
            speed_q <= `SC_RPM_SAFE;
        end else begin
            tick_q <= tickHit ? 32'h0 : tick_q + 32'h1;
            if (tickHit && ramp_q != 8'h0) begin
                if (speed_q + 16'(ramp_q) <= capped) begin
                    speed_q <= speed_q + 16'(ramp_q);
                end else if (speed_q >= capped + 16'(ramp_q)) begin
                    speed_q <= speed_q - 16'(ramp_q);
                end else begin
                    speed_q <= capped;
                end
            end
        end
    end

    // Ignition bypass; the automatic release wins over a new request.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bypass_q <= 1'b0;
            bypassClr_q <= 1'b0;
        end else begin
            bypassClr_q <= bypass_q && speed_q > `SC_RPM_BYPASS;
            if (speed_q > `SC_RPM_BYPASS) begin
                bypass_q <= 1'b0;
            end else if (bpEdge) begin
                bypass_q <= 1'b1;
            end
        end
    end

    // Sticky events: a new event in the clearing cycle stays set.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqSt_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            irqSt_q <= (irqSt_q & ~((wbWr && wbAdr == `SC_DEV_IRQCLR) ?
                wbDatW[2:0] : 3'h0)) | {bypassClr_q,
                tickHit && canActive_q && idle_q + 16'h1 >= tmo_q,
                frameOk_q && rxShift_q[92:64] == `SC_REQ_ID};
            irq_q <= |(irqSt_q & irqEn_q);
        end
    end

    // Wishbone slave: one wait state, registered data, unmapped reads 0.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wbAck_q <= 1'b0;
            wbDatR_q <= 32'h0;
        end else begin
            wbAck_q <= wbCyc && wbStb && !wbAck_q;
            unique case (wbAdr)
                `SC_DEV_CTRL: wbDatR_q <= {28'h0, ctrl_q};
                `SC_DEV_SETPT: wbDatR_q <= {14'h0, stage_q, setpt_q};
                `SC_DEV_RAMP: wbDatR_q <= {24'h0, ramp_q};
                `SC_DEV_TMO: wbDatR_q <= {16'h0, tmo_q};
                `SC_DEV_STAT: wbDatR_q <= {speed_q, 12'h0, rate250,
                    bypass_q, msgFail_q, canActive_q};
                `SC_DEV_IRQST: wbDatR_q <= {29'h0, irqSt_q};
                `SC_DEV_IRQEN: wbDatR_q <= {29'h0, irqEn_q};
                default: wbDatR_q <= 32'h0;
            endcase
        end
    end

    // Wired inputs are live whenever no active request holds them.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hwInputsEnabled <= 1'b1;
        end else begin
            hwInputsEnabled <= !canActive_q;
        end
    end

    assign wbAck = wbAck_q;
    assign wbDatR = wbDatR_q;
    assign speedCmd = speed_q;
    assign bypassActive = bypass_q;
    assign irq = irq_q;
endmodule

// ===== core/speed_ctrl_host.sv
// Converter controller end: sends the target speed request frame.
`timescale 1ns/1ps
`include "speed_ctrl_params.svh"
module speed_ctrl_host import speed_ctrl_pkg::*; (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    speed_link_if.host link,
    output logic busy
);
    logic [15:0] speed_q;
    logic [1:0] ctrl_q;
    logic wbAck_q;
    logic [31:0] wbDatR_q;
    txState_t txState_q;
    logic [93:0] txShift_q;
    logic [15:0] txCnt_q;
    logic [6:0] txBits_q;
    logic txOut_q, txOe_q, busy_q;
    logic wbWr, bitEnd;
    logic [15:0] bitCycles;
    logic [63:0] payload;

    assign wbWr = wbCyc && wbStb && wbWe && !wbAck_q && wbSel[0];
    assign bitCycles = ctrl_q[1] ? 16'(`SC_BIT_250K) : 16'(`SC_BIT_500K);
    assign bitEnd = txCnt_q == bitCycles - 16'h1;

    always_comb begin
        payload = 64'h0;
        payload[`SC_ACT_BIT] = ctrl_q[0];
        payload[`SC_SPEED_LSB +: `SC_SPEED_LEN] = speed_q;
    end

    // Request registers written by software.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            speed_q <= 16'h0;
            ctrl_q <= 2'h0;
        end else if (wbWr && wbAdr == `SC_HST_SPEED) begin
            speed_q <= wbDatW[15:0];
        end else if (wbWr && wbAdr == `SC_HST_CTRL) begin
            ctrl_q <= wbDatW[1:0];
        end
    end

    // Transmitter: start bit, identifier, payload, then a recessive gap.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txState_q <= TxIdle;
            txShift_q <= '1;
            txCnt_q <= 16'h0;
            txBits_q <= 7'h0;
            busy_q <= 1'b0;
        end else begin
            unique case (txState_q)
                TxIdle: begin
                    if (wbWr && wbAdr == `SC_HST_SEND) begin
                        txShift_q <= {1'b0, `SC_REQ_ID, reverse64(payload)};
                        txCnt_q <= 16'h0;
                        txBits_q <= 7'h0;
                        busy_q <= 1'b1;
                        txState_q <= TxBits;
                    end
                end
                TxBits: begin
                    txCnt_q <= bitEnd ? 16'h0 : txCnt_q + 16'h1;
                    if (bitEnd) begin
                        txShift_q <= {txShift_q[92:0], 1'b1};
                        txBits_q <= txBits_q + 7'h1;
                        if (txBits_q == 7'(`SC_FRAME_BITS)) begin
                            txBits_q <= 7'h0;
                            txState_q <= TxGap;
                        end
                    end
                end
                TxGap: begin
                    txCnt_q <= bitEnd ? 16'h0 : txCnt_q + 16'h1;
                    if (bitEnd) begin
                        txBits_q <= txBits_q + 7'h1;
                        if (txBits_q == 7'(`SC_GAP_BITS - 1)) begin
                            busy_q <= 1'b0;
                            txState_q <= TxIdle;
                        end
                    end
                end
            endcase
        end
    end

    // Line driver: only dominant bits are driven, recessive floats high.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txOut_q <= 1'b1;
            txOe_q <= 1'b0;
        end else begin
            txOut_q <= 1'b0;
            txOe_q <= txState_q == TxBits && !txShift_q[93];
        end
    end

    // Wishbone slave with one wait state; unmapped reads return zero.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wbAck_q <= 1'b0;
            wbDatR_q <= 32'h0;
        end else begin
            wbAck_q <= wbCyc && wbStb && !wbAck_q;
            unique case (wbAdr)
                `SC_HST_SPEED: wbDatR_q <= {16'h0, speed_q};
                `SC_HST_CTRL: wbDatR_q <= {30'h0, ctrl_q};
                `SC_HST_STAT: wbDatR_q <= {31'h0, busy_q};
                default: wbDatR_q <= 32'h0;
            endcase
        end
    end

    assign link.hostOut = txOut_q;
    assign link.hostOe = txOe_q;
    assign wbAck = wbAck_q;
    assign wbDatR = wbDatR_q;
    assign busy = busy_q;
endmodule

// ===== verification/speed_link_checker.sv
// Checker for the serial line between the converter and device ends.
`timescale 1ns/1ps
module speed_link_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic hostOut,
    input wire logic hostOe,
    input wire logic devOut,
    input wire logic devOe,
    input wire logic line
);
    logic [15:0] runLen_q;
    logic lastOe_q;
    logic seen_q;
    logic lead_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Run length of the host drive; it saturates so long idles never wrap.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            runLen_q <= 16'h0000;
            lastOe_q <= 1'b0;
        end else begin
            lastOe_q <= hostOe;
            if (hostOe != lastOe_q) begin
                runLen_q <= 16'h0001;
            end else if (runLen_q != 16'hffff) begin
                runLen_q <= runLen_q + 16'h0001;
            end
        end
    end

    // A rise after a long recessive stretch marks the start bit of a frame.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_q <= 1'b0;
            lead_q <= 1'b0;
        end else if (hostOe && !lastOe_q) begin
            seen_q <= 1'b1;
            lead_q <= (runLen_q >= 16'h0898);
        end else if (!hostOe && lastOe_q) begin
            lead_q <= 1'b0;
        end
    end

    AST_DOM_LOW: assert property (hostOe |-> !hostOut)
        else $error("host enables a recessive level");
    AST_BIT_CELL: assert property (
        $fell(hostOe) |-> (runLen_q % 16'h00c8) == 16'h0000)
        else $error("dominant run is not whole bit cells");
    AST_RECESSIVE_CELL: assert property (
        $rose(hostOe) && seen_q |->
        (runLen_q % 16'h00c8) == 16'h0000 || runLen_q >= 16'h0898)
        else $error("recessive run is neither bit cells nor a gap");
    AST_START_BIT: assert property (
        $fell(hostOe) && lead_q |->
        runLen_q == 16'h00c8 || runLen_q == 16'h0190)
        else $error("start bit is not followed by a set identifier msb");
    AST_DOM_BOUND: assert property (hostOe |-> runLen_q <= 16'h6400)
        else $error("dominant run longer than a frame allows");
    AST_DEV_QUIET: assert property (!devOe)
        else $error("device drives the line");
    AST_DEV_RECESSIVE: assert property (devOut)
        else $error("device output left dominant");
    AST_LINE_IDLE: assert property (!hostOe |-> line)
        else $error("line low with no driver");
endmodule

// ===== verification/can_target_speed_control_test.sv
// Self-checking bench joining the converter end to the device end.
`timescale 1ns/1ps
`include "speed_ctrl_params.svh"
module can_target_speed_control_test import speed_ctrl_pkg::*;;
    logic clk, rst_b, cyc, we, toHost, dAck, hAck, busy, byA, hwEn, irq;
    logic [2:0] pins;
    logic [4:0] adr;
    logic [15:0] lim, v;
    logic [31:0] datW, dDatR, hDatR;
    rpm_t speedCmd;
    logic [63:0] pend[$];
    logic [15:0] stg[4];
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    integer seed;
    wire ack = toHost ? hAck : dAck;
    wire [31:0] datR = toHost ? hDatR : dDatR;

    speed_link_if lnk();
    speed_ctrl_device #(.TickCycles(20)) i_speed_ctrl_device (.clk(clk),
        .rst_b(rst_b), .wbCyc(cyc & ~toHost), .wbStb(cyc & ~toHost),
        .wbWe(we), .wbAdr(adr), .wbSel(4'hf), .wbDatW(datW), .wbDatR(dDatR),
        .wbAck(dAck), .link(lnk), .speedUpPin(pins[0]),
        .speedDownPin(pins[1]), .bypassReqPin(pins[2]), .protectLimit(lim),
        .speedCmd(speedCmd), .bypassActive(byA), .hwInputsEnabled(hwEn),
        .irq(irq));
    speed_ctrl_host i_speed_ctrl_host (.clk(clk), .rst_b(rst_b),
        .wbCyc(cyc & toHost), .wbStb(cyc & toHost), .wbWe(we),
        .wbAdr(adr[3:0]), .wbSel(4'hf), .wbDatW(datW), .wbDatR(hDatR),
        .wbAck(hAck), .link(lnk), .busy(busy));
    speed_link_checker i_speed_link_checker (.clk(clk), .rst_b(rst_b),
        .hostOut(lnk.hostOut), .hostOe(lnk.hostOe), .devOut(lnk.devOut),
        .devOe(lnk.devOe), .line(lnk.line));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // One classic cycle; for a read, d is the expected word under mask m.
    task automatic access(input logic h, w, input logic [4:0] a,
        input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
        int g;
        g = 0;
        @(posedge clk);
        toHost <= h;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        datW <= w ? d : 32'h0;
        if (!w) pend.push_back({m, d});
        @(posedge clk);
        while (ack !== 1'b1 && g < 50) begin
            g++;
            @(posedge clk);
        end
        if (g == 50) check("bus ack", 32'h0, 32'h1);
        cyc <= 1'b0;
    endtask

    task automatic waitSpeed(input logic [15:0] exp);
        int g;
        g = 0;
        while (speedCmd !== exp && g < 3000) begin
            g++;
            @(posedge clk);
        end
        check("speedCmd", {16'h0, speedCmd}, {16'h0, exp});
    endtask

    // Wired inputs are slow levels, so each pulse is held for several clocks.
    task automatic pulse(input logic [2:0] p);
        @(posedge clk);
        pins <= p;
        repeat (6) @(posedge clk);
        pins <= 3'h0;
        repeat (6) @(posedge clk);
    endtask

    task automatic sendFrame(input logic [31:0] spd, act);
        int g;
        g = 0;
        access(1'b1, 1'b1, 5'(`SC_HST_SPEED), spd);
        access(1'b1, 1'b1, 5'(`SC_HST_CTRL), act);
        access(1'b1, 1'b1, 5'(`SC_HST_SEND), 32'h0);
        repeat (3) @(posedge clk);
        while (busy === 1'b1 && g < 30000) begin
            g++;
            @(posedge clk);
        end
        check("busy", {31'h0, busy}, 32'h0);
        repeat (10) @(posedge clk);
    endtask

    function automatic logic [15:0] clampRpm(input logic [15:0] x);
        if (x > `SC_RPM_MAX) return `SC_RPM_MAX;
        if (x < `SC_RPM_MIN) return `SC_RPM_MIN;
        return x - (x % `SC_RPM_STEP);
    endfunction

    // Oldest expected read is compared when its acknowledge is sampled.
    always @(posedge clk) begin
        logic [63:0] e;
        if (cyc && !we && ack === 1'b1 && pend.size() > 0) begin
            e = pend.pop_front();
            check("read data", datR & e[63:32], e[31:0]);
        end
    end

    // A hang is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 95000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        seed = 32'h0541dd15;
        stg = '{`SC_RPM_MIN, `SC_RPM_STAGE1, `SC_RPM_STAGE2, `SC_RPM_STAGE2};
        {cyc, we, toHost, pins, adr, datW, rst_b} = '0;
        lim = 16'hffff;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("speedCmd", {16'h0, speedCmd}, 32'h3e8);
        check("wired", {hwEn, byA, irq}, 32'h4);
        access(1'b0, 1'b0, `SC_DEV_RAMP, 32'h0a);
        access(1'b0, 1'b0, `SC_DEV_SETPT, 32'h3e8);
        access(1'b0, 1'b0, `SC_DEV_IRQCLR, 32'h0);
        $display("test reset done");
        access(1'b0, 1'b1, `SC_DEV_CTRL, 32'h9);
        access(1'b0, 1'b1, `SC_DEV_RAMP, 32'h0);
        access(1'b0, 1'b1, `SC_DEV_SETPT, 32'h7d0);
        repeat (200) @(posedge clk);
        check("frozen", {16'h0, speedCmd}, 32'h3e8);
        pulse(3'h4);
        check("bypass on", {31'h0, byA}, 32'h1);
        access(1'b0, 1'b1, `SC_DEV_IRQEN, 32'h4);
        access(1'b0, 1'b1, `SC_DEV_RAMP, 32'h64);
        waitSpeed(16'h07d0);
        check("bypass off", {30'h0, byA, irq}, 32'h1);
        access(1'b0, 1'b0, `SC_DEV_IRQST, 32'h4, 32'h4);
        access(1'b0, 1'b1, `SC_DEV_IRQCLR, 32'h4);
        repeat (3) @(posedge clk);
        check("irq", {31'h0, irq}, 32'h0);
        $display("test ramp and bypass done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 16'd5000 : (i == 1) ? 16'd1250 : 16'd900;
            if (i == 3) v = 16'd900 + 16'({$random(seed)} % 3500);
            access(1'b0, 1'b1, `SC_DEV_SETPT, {16'h0, v});
            access(1'b0, 1'b0, `SC_DEV_SETPT, {16'h0, clampRpm(v)});
        end
        access(1'b0, 1'b1, `SC_DEV_SETPT, 32'h0ed8);
        lim <= 16'h05dc;
        waitSpeed(16'h05dc);
        lim <= 16'hffff;
        $display("test limits done");
        access(1'b0, 1'b1, `SC_DEV_CTRL, 32'h8);
        for (int s = 0; s < 4; s++) begin
            access(1'b0, 1'b1, `SC_DEV_SETPT, {14'h0, 2'(s), 16'h0bb8});
            waitSpeed(stg[s]);
        end
        access(1'b0, 1'b1, `SC_DEV_CTRL, 32'h2);
        access(1'b0, 1'b0, `SC_DEV_STAT, 32'h8, 32'h8);
        access(1'b0, 1'b1, `SC_DEV_CTRL, 32'h6);
        access(1'b0, 1'b0, `SC_DEV_STAT, 32'h0, 32'h8);
        $display("test stages and rates done");
        access(1'b0, 1'b1, `SC_DEV_CTRL, 32'h9);
        access(1'b0, 1'b1, `SC_DEV_TMO, 32'h1388);
        access(1'b0, 1'b1, `SC_DEV_SETPT, 32'h5dc);
        sendFrame(32'h0fa0, 32'h1);
        waitSpeed(16'h0ed8);
        check("wired", {31'h0, hwEn}, 32'h0);
        pulse(3'h1);
        access(1'b0, 1'b0, `SC_DEV_SETPT, 32'h5dc, 32'hffff);
        sendFrame(32'h09c4, 32'h0);
        check("wired", {31'h0, hwEn}, 32'h1);
        waitSpeed(16'h05dc);
        pulse(3'h1);
        access(1'b0, 1'b0, `SC_DEV_SETPT, 32'h640, 32'hffff);
        pulse(3'h2);
        access(1'b0, 1'b0, `SC_DEV_SETPT, 32'h5dc, 32'hffff);
        sendFrame(32'h09c4, 32'h1);
        waitSpeed(16'h09c4);
        access(1'b0, 1'b1, `SC_DEV_TMO, 32'h2);
        for (int g = 0; g < 500 && hwEn !== 1'b1; g++) @(posedge clk);
        check("wired", {31'h0, hwEn}, 32'h1);
        access(1'b0, 1'b0, `SC_DEV_STAT, 32'h2, 32'h3);
        access(1'b0, 1'b0, `SC_DEV_IRQST, 32'h3, 32'h7);
        $display("test link frames done");
        results();
    end
endmodule
